// ---- pwm_timer.sv ----
// five-channel pwm timer with apb register file and one interrupt line
// assumes apb master on pclk; presetn asynchronous, active low
`timescale 1ns/100ps

module pwm_timer
	import pwm_timer_pkg::*;
#(
	parameter int CW = CNT_W
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [NCMP-1:0]  pwm_out,
	output logic             pwm0_n,
	output logic             irq
);

	logic [31:0]      ctrl_q;
	logic [23:0]      presc_q;
	logic [1:0]       divsel_q   [NTMR];
	logic [CW-1:0]    cnt_buf_q  [NTMR];
	logic [CW-1:0]    cmp_buf_q  [NCMP];
	logic [NTMR-1:0]  istat_q;
	logic [NTMR-1:0]  imask_q;
	logic [NTMR-1:0]  istat_d;
	logic [31:0]      rdata_q;
	logic [31:0]      rd_d;
	logic             pready_q;
	logic             pslverr_q;
	logic             irq_q;
	logic             hit;
	logic             setup;
	logic             wr_en;
	logic             wr_ctrl;
	logic [NTMR-1:0]  upd_wr;
	logic [NTMR-1:0]  tick;
	logic [NTMR-1:0]  zero;
	logic [NTMR-1:0]  level;
	logic [CW-1:0]    count      [NTMR];
	logic [PRE_W-1:0] pre_cnt_q  [2];
	logic [3:0]       div_cnt_q  [2];
	logic [1:0]       pre_tick;
	logic [NCMP-1:0]  pwm_q;
	logic             pwm0_n_q;
	logic             lvl0;
	logic             lvl0_prev_q;
	logic [7:0]       dead_cnt_q;
	logic             dead_gap;
	chan_ctrl_t       c0;

	assign prdata  = rdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign pwm_out = pwm_q;
	assign pwm0_n  = pwm0_n_q;
	assign irq     = irq_q;

	// apb phases; writes land on the access edge, reads are captured at setup
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pready_q && pwrite;
	assign wr_ctrl = wr_en && paddr == CTRL_ADDR;
	assign c0      = ctrl_of(ctrl_q, 0);

	// read mux and address decode
	always_comb begin
		rd_d = REG_RESET;
		hit  = 1'b0;
		if (paddr == CTRL_ADDR) begin
			rd_d = ctrl_q;
			hit  = 1'b1;
		end
		if (paddr == PRESC_ADDR) begin
			rd_d = {8'h00, presc_q};
			hit  = 1'b1;
		end
		if (paddr == DIVSEL_ADDR) begin
			for (int i = 0; i < NTMR; i++) begin
				rd_d[DIV_STRIDE*i +: 2] = divsel_q[i];
			end
			hit = 1'b1;
		end
		if (paddr == ISTAT_ADDR) begin
			rd_d = {27'h0, istat_q};
			hit  = 1'b1;
		end
		if (paddr == IMASK_ADDR) begin
			rd_d = {27'h0, imask_q};
			hit  = 1'b1;
		end
		for (int i = 0; i < NTMR; i++) begin
			if (paddr == CNT_BUF_ADDR[i]) begin
				rd_d = {16'h0000, cnt_buf_q[i]};
				hit  = 1'b1;
			end
			if (paddr == OBS_ADDR[i]) begin
				rd_d = {16'h0000, count[i]};
				hit  = 1'b1;
			end
		end
		for (int i = 0; i < NCMP; i++) begin
			if (paddr == CMP_BUF_ADDR[i]) begin
				rd_d = {16'h0000, cmp_buf_q[i]};
				hit  = 1'b1;
			end
		end
	end

	// one wait-free access phase; unmapped addresses answer with pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			rdata_q   <= REG_RESET;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !hit;
			if (setup) begin
				rdata_q <= pwrite ? REG_RESET : rd_d;
			end
		end
	end

	// control word; reserved bits are masked so they never reach the timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= REG_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata & CTRL_MASK;
		end
	end

	// update fires on each write carrying a one; the bit kept in ctrl_q triggers nothing,
	// so a later write repeats the load only if its own data carries the one again
	always_comb begin
		for (int n = 0; n < NTMR; n++) begin
			upd_wr[n] = wr_ctrl && pwdata[slot_base(n) + T_UPD];
		end
	end

	// count and compare buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NTMR; i++) begin
				cnt_buf_q[i] <= '0;
			end
			for (int i = 0; i < NCMP; i++) begin
				cmp_buf_q[i] <= '0;
			end
		end else if (wr_en) begin
			for (int i = 0; i < NTMR; i++) begin
				if (paddr == CNT_BUF_ADDR[i]) begin
					cnt_buf_q[i] <= pwdata[CW-1:0];
				end
			end
			for (int i = 0; i < NCMP; i++) begin
				if (paddr == CMP_BUF_ADDR[i]) begin
					cmp_buf_q[i] <= pwdata[CW-1:0];
				end
			end
		end
	end

	// prescaler, dead length and divider selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= '0;
			for (int i = 0; i < NTMR; i++) begin
				divsel_q[i] <= 2'h0;
			end
		end else if (wr_en) begin
			if (paddr == PRESC_ADDR) begin
				presc_q <= pwdata[23:0];
			end
			if (paddr == DIVSEL_ADDR) begin
				for (int i = 0; i < NTMR; i++) begin
					divsel_q[i] <= pwdata[DIV_STRIDE*i +: 2];
				end
			end
		end
	end

	// two prescaler groups: timers 0-1 and timers 2-4
	always_comb begin
		pre_tick[0] = pre_cnt_q[0] == presc_q[PRE0_LSB +: PRE_W];
		pre_tick[1] = pre_cnt_q[1] == presc_q[PRE1_LSB +: PRE_W];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int g = 0; g < 2; g++) begin
				pre_cnt_q[g] <= '0;
				div_cnt_q[g] <= 4'h0;
			end
		end else begin
			for (int g = 0; g < 2; g++) begin
				pre_cnt_q[g] <= pre_tick[g] ? '0 : pre_cnt_q[g] + 1'b1;
				if (pre_tick[g]) begin
					div_cnt_q[g] <= div_cnt_q[g] + 4'h1;
				end
			end
		end
	end

	// per-timer tick from its group's divider chain
	always_comb begin
		for (int n = 0; n < NTMR; n++) begin
			tick[n] = pre_tick[n / 2 > 0 ? 1 : 0]
				&& (div_cnt_q[n / 2 > 0 ? 1 : 0] & div_mask(divsel_q[n])) == div_mask(divsel_q[n]);
		end
	end

	// timer 4 has no compare buffer; its index folds to 0 and the channel ignores it
	for (genvar n = 0; n < NTMR; n++) begin : g_chan
		pwm_chan #(
			.HAS_CMP (n < NCMP),
			.CW      (CW)
		) u_chan (
			.pclk    (pclk),
			.presetn (presetn),
			.tick    (tick[n]),
			.ctrl    (ctrl_of(ctrl_q, n)),
			.upd_wr  (upd_wr[n]),
			.cnt_buf (cnt_buf_q[n]),
			.cmp_buf (cmp_buf_q[n % NCMP]),
			.count_q (count[n]),
			.level_q (level[n]),
			.zero_q  (zero[n])
		);
	end

	// timer 0 level after the inverter, then dead zone on the pair
	assign lvl0     = level[0] ^ c0.inv;
	assign dead_gap = ctrl_q[DEAD_EN_BIT]
		&& ((lvl0 != lvl0_prev_q) ? presc_q[DEAD_LSB +: 8] != 8'h00 : dead_cnt_q != 8'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl0_prev_q <= 1'b0;
			dead_cnt_q  <= 8'h00;
		end else begin
			lvl0_prev_q <= lvl0;
			if (lvl0 != lvl0_prev_q) begin
				dead_cnt_q <= presc_q[DEAD_LSB +: 8];
			end else if (tick[0] && dead_cnt_q != 8'h00) begin
				dead_cnt_q <= dead_cnt_q - 8'h01;
			end
		end
	end

	// registered pin outputs; both halves of the pair stay low through the gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_q    <= '0;
			pwm0_n_q <= 1'b0;
		end else begin
			pwm_q[0] <= lvl0 && !dead_gap;
			pwm0_n_q <= !lvl0 && !dead_gap;
			for (int n = 1; n < NCMP; n++) begin
				pwm_q[n] <= level[n] ^ ctrl_q[slot_base(n) + T_INV];
			end
		end
	end

	// sticky zero events; a new event beats a write-one-to-clear
	always_comb begin
		istat_d = istat_q;
		if (wr_en && paddr == ISTAT_ADDR) begin
			istat_d = istat_q & ~pwdata[NTMR-1:0];
		end
		istat_d = istat_d | zero;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= '0;
			imask_q <= '0;
			irq_q   <= 1'b0;
		end else begin
			istat_q <= istat_d;
			if (wr_en && paddr == IMASK_ADDR) begin
				imask_q <= pwdata[NTMR-1:0];
			end
			irq_q <= |(istat_q & imask_q);
		end
	end

	// checks
	sequence s_ctrl_upd0;
		wr_ctrl && pwdata[T_UPD];
	endsequence

	sequence s_rd_obs0;
		setup && !pwrite && paddr == OBS_ADDR[0];
	endsequence

	a_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> ctrl_q == '0 && cnt_buf_q[0] == '0 && count[0] == '0)
		else $error("state not clear after reset");

	a_rsv_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ctrl_q[7:5] == 3'h0 && ctrl_q[4:0] == $past(pwdata[4:0]))
		else $error("control low byte wrong after write");

	a_manual_upd: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_upd0 |=> count[0] == $past(cnt_buf_q[0]) && !level[0])
		else $error("manual update did not load timer 0");

	a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
		tick[0] && c0.start && !c0.reload && count[0] == '0 && !upd_wr[0] |=> count[0] == '0)
		else $error("one-shot timer 0 left zero");

	a_auto_reload: assert property (@(posedge pclk) disable iff (!presetn)
		tick[0] && c0.start && c0.reload && count[0] == '0 && !upd_wr[0]
		|=> count[0] == $past(cnt_buf_q[0]))
		else $error("interval timer 0 did not reload");

	a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!c0.start && !upd_wr[0] |=> $stable(count[0]))
		else $error("stopped timer 0 counted");

	a_invert_out: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> pwm_q[1] == ($past(level[1]) ^ $past(ctrl_q[slot_base(1) + T_INV])))
		else $error("timer 1 output polarity wrong");

	a_dead_gap: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[DEAD_EN_BIT] && lvl0 != lvl0_prev_q && presc_q[DEAD_LSB +: 8] != 8'h00
		|=> !pwm_q[0] && !pwm0_n_q)
		else $error("dead zone gap missing");

	a_buf_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == CNT_BUF_ADDR[1] |=> cnt_buf_q[1] == $past(pwdata[CW-1:0]))
		else $error("count buffer 1 not written");

	a_obs_read: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_obs0 |=> pready && !pslverr && prdata == {16'h0000, $past(count[0])})
		else $error("observation read wrong");

	a_tick_space: assert property (@(posedge pclk) disable iff (!presetn)
		tick[0] |=> !tick[0])
		else $error("tick faster than half pclk");

	a_zero_irq: assert property (@(posedge pclk) disable iff (!presetn)
		zero[0] && imask_q[0] |=> istat_q[0] ##1 irq)
		else $error("zero event lost or no interrupt");

endmodule // pwm_timer

// ---- pwm_timer_pkg.sv ----
// pwm timer package: register map, control word layout, carrier types
// assumes a 32-bit apb slave decoding full byte addresses
package pwm_timer_pkg;

	localparam int NTMR  = 5;  // timers 0..4
	localparam int NCMP  = 4;  // timers 0..3 own a compare buffer
	localparam int CNT_W = 16; // counter and buffer width
	localparam int PRE_W = 8;  // prescaler width

	localparam logic [31:0] PRESC_ADDR  = 32'h5100_0000;
	localparam logic [31:0] DIVSEL_ADDR = 32'h5100_0004;
	localparam logic [31:0] CTRL_ADDR   = 32'h5100_0008;
	localparam logic [31:0] ISTAT_ADDR  = 32'h5100_0044;
	localparam logic [31:0] IMASK_ADDR  = 32'h5100_0048;

	localparam logic [31:0] CNT_BUF_ADDR [NTMR] = '{32'h5100_000C, 32'h5100_0018,
		32'h5100_0024, 32'h5100_0030, 32'h5100_003C};
	localparam logic [31:0] CMP_BUF_ADDR [NCMP] = '{32'h5100_0010, 32'h5100_001C,
		32'h5100_0028, 32'h5100_0034};
	localparam logic [31:0] OBS_ADDR [NTMR] = '{32'h5100_0014, 32'h5100_0020,
		32'h5100_002C, 32'h5100_0038, 32'h5100_0040};

	// control word fields: offsets inside one timer slot, then absolute bit numbers
	localparam int T_START     = 0;
	localparam int T_UPD       = 1;
	localparam int T_INV       = 2;
	localparam int T_RLD       = 3;
	localparam int DEAD_EN_BIT = 4;
	localparam int T4_RLD_BIT  = 22;
	localparam logic [31:0] CTRL_MASK = 32'h007F_FF1F; // reserved bits stay zero

	// prescaler register fields
	localparam int PRE0_LSB = 0;
	localparam int PRE1_LSB = 8;
	localparam int DEAD_LSB = 16;
	localparam int DIV_STRIDE = 4; // one divider select nibble per timer

	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	typedef struct packed {
		logic start;
		logic upd;
		logic inv;
		logic reload;
	} chan_ctrl_t;

	// lowest control bit of timer n
	function automatic int slot_base(input int n);
		return (n == 0) ? 0 : 4 + 4 * n;
	endfunction

	// pick one timer's controls out of a control word; timer 4 has no inverter
	function automatic chan_ctrl_t ctrl_of(input logic [31:0] c, input int n);
		chan_ctrl_t r;
		r.start  = c[slot_base(n) + T_START];
		r.upd    = c[slot_base(n) + T_UPD];
		r.inv    = (n == NTMR - 1) ? 1'b0 : c[slot_base(n) + T_INV];
		r.reload = (n == NTMR - 1) ? c[T4_RLD_BIT] : c[slot_base(n) + T_RLD];
		return r;
	endfunction

	// divider select 0..3 gives a mask whose all-ones point divides by 2..16
	function automatic logic [3:0] div_mask(input logic [1:0] sel);
		return 4'((5'h02 << sel) - 5'h01);
	endfunction

endpackage

// ---- pwm_chan.sv ----
// one down-counting pwm timer channel
// assumes a one-cycle tick strobe and an update strobe from the register block
`timescale 1ns/100ps

module pwm_chan
	import pwm_timer_pkg::*;
#(
	parameter bit HAS_CMP = 1'b1,
	parameter int CW      = CNT_W
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          tick,
	input  wire chan_ctrl_t    ctrl,
	input  wire logic          upd_wr,
	input  wire logic [CW-1:0] cnt_buf,
	input  wire logic [CW-1:0] cmp_buf,
	output logic      [CW-1:0] count_q,
	output logic               level_q,
	output logic               zero_q
);

	logic [CW-1:0] cmp_q;
	logic          step;

	assign step = tick && ctrl.start;

	// working counter; an update beats a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			cmp_q   <= '0;
		end else if (upd_wr) begin
			count_q <= cnt_buf;
			cmp_q   <= HAS_CMP ? cmp_buf : '0;
		end else if (step) begin
			if (count_q != '0) begin
				count_q <= count_q - 1'b1;
			end else if (ctrl.reload) begin
				count_q <= cnt_buf;
				cmp_q   <= HAS_CMP ? cmp_buf : '0;
			end
		end
	end

	// zero event fires once, on the step that lands on zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_q <= 1'b0;
		end else begin
			zero_q <= !upd_wr && step && count_q == CW'(1);
		end
	end

	// output low after a load, high from the compare match on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'b0;
		end else if (upd_wr) begin
			level_q <= 1'b0;
		end else if (step && HAS_CMP) begin
			if (count_q == '0) begin
				level_q <= 1'b0;
			end else if (count_q - 1'b1 == cmp_q) begin
				level_q <= 1'b1;
			end
		end
	end

endmodule // pwm_chan

// ---- pwm_timer_test.sv ----
// testbench for pwm_timer: apb register tests and timer 0 behaviour at the pins
// assumes the apb slave answers with pready under a bounded wait; no partner model
`timescale 1ns/100ps

module pwm_timer_test
	import pwm_timer_pkg::*;
;
	logic            pclk;
	logic            presetn;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [31:0]     paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic [NCMP-1:0] pwm_out;
	logic            pwm0_n;
	logic            irq;
	logic [31:0]     rdat;
	logic            serr;
	logic [31:0]     snap;
	int              fails;
	int              check_count;
	int              upd_bit [NTMR] = '{1, 9, 13, 17, 21}; // manual update bit per timer

	pwm_timer dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.pwm_out (pwm_out),
		.pwm0_n  (pwm0_n),
		.irq     (irq)
	);

	// 20 MHz clock
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("mismatch t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	// no cycle limit here: a slave that never answers is caught by the watchdog
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a);
		xfer(1'b0, a, 32'h0000_0000);
	endtask

	task automatic pins(input logic [1:0] e);
		repeat (3) @(posedge pclk);
		check({30'h0, pwm_out[0], pwm0_n}, {30'h0, e});
	endtask

	// hang guard; the whole run needs only about a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		report_and_stop();
	end

	initial begin
		psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
		fails = 0; check_count = 0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values of the buffer, observation and control registers
		for (int n = 0; n < NTMR; n++) begin
			rd(CNT_BUF_ADDR[n]); check(rdat, REG_RESET);
			rd(OBS_ADDR[n]); check(rdat, REG_RESET);
		end
		for (int n = 0; n < NCMP; n++) begin
			rd(CMP_BUF_ADDR[n]); check(rdat, REG_RESET);
		end
		rd(CTRL_ADDR); check(rdat, REG_RESET);
		// buffers keep 16 bits; observation ignores writes
		for (int n = 0; n < NTMR; n++) begin
			wr(CNT_BUF_ADDR[n], 32'hFFFF_8001 + n);
			rd(CNT_BUF_ADDR[n]); check(rdat, 32'h0000_8001 + n);
			wr(OBS_ADDR[n], 32'h0000_1234);
			rd(OBS_ADDR[n]); check(rdat, REG_RESET);
		end
		for (int n = 0; n < NCMP; n++) begin
			wr(CMP_BUF_ADDR[n], 32'hFFFF_8101 + n);
			rd(CMP_BUF_ADDR[n]); check(rdat, 32'h0000_8101 + n);
		end
		// the address after the interrupt mask register is unmapped and answers with pslverr
		rd(32'h5100_004C); check({31'h0, serr}, 32'h1);
		// reserved control bits drop, reload bit stays
		wr(CTRL_ADDR, 32'hFF80_00E8);
		rd(CTRL_ADDR); check(rdat, 32'h0000_0008);
		// manual update of each timer copies its count buffer
		for (int n = 0; n < NTMR; n++) begin
			wr(CTRL_ADDR, 32'h1 << upd_bit[n]);
			wr(CTRL_ADDR, 32'h0000_0000);
			rd(OBS_ADDR[n]); check(rdat, 32'h0000_8001 + n);
		end
		// inverters of timers 1-3 flip their idle low outputs
		wr(CTRL_ADDR, 32'h0004_4400);
		repeat (3) @(posedge pclk);
		check({29'h0, pwm_out[3:1]}, 32'h0000_0007);
		wr(CTRL_ADDR, 32'h0000_0000);
		// timer 0 one-shot, tick every 2 cycles
		wr(CNT_BUF_ADDR[0], 32'h0000_000A);
		wr(CMP_BUF_ADDR[0], 32'h0000_0004);
		wr(CTRL_ADDR, 32'h0000_0002);
		wr(CTRL_ADDR, 32'h0000_0000);
		rd(OBS_ADDR[0]); check(rdat, 32'h0000_000A);
		pins(2'b01);
		wr(CTRL_ADDR, 32'h0000_0004);
		pins(2'b10);
		wr(CTRL_ADDR, 32'h0000_0000);
		wr(IMASK_ADDR, 32'h0000_0001);
		wr(CTRL_ADDR, 32'h0000_0001);
		// output is high from the step onto the compare value until the tick at zero
		repeat (15) @(posedge pclk);
		pins(2'b10);
		repeat (40) @(posedge pclk);
		rd(OBS_ADDR[0]); check(rdat, REG_RESET);
		pins(2'b01);
		rd(ISTAT_ADDR); check(rdat, 32'h0000_0001);
		check({31'h0, irq}, 32'h1);
		wr(IMASK_ADDR, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		wr(IMASK_ADDR, 32'h0000_0001);
		wr(ISTAT_ADDR, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		// a stopped one-shot timer raises no further zero event
		repeat (60) @(posedge pclk);
		rd(ISTAT_ADDR); check(rdat, 32'h0000_0000);
		// interval mode keeps producing zero events
		wr(CTRL_ADDR, 32'h0000_000A);
		wr(CTRL_ADDR, 32'h0000_0009);
		repeat (60) @(posedge pclk);
		wr(ISTAT_ADDR, 32'h0000_0001);
		repeat (60) @(posedge pclk);
		rd(ISTAT_ADDR); check(rdat, 32'h0000_0001);
		// a stopped counter holds its value
		wr(CTRL_ADDR, 32'h0000_0008);
		rd(OBS_ADDR[0]);
		snap = rdat;
		repeat (20) @(posedge pclk);
		rd(OBS_ADDR[0]); check(rdat, snap);
		// dead zone of 4 ticks on a polarity change
		wr(PRESC_ADDR, 32'h0004_0000);
		wr(CTRL_ADDR, 32'h0000_0012);
		wr(CTRL_ADDR, 32'h0000_0010);
		repeat (40) @(posedge pclk);
		pins(2'b01);
		wr(CTRL_ADDR, 32'h0000_0014);
		pins(2'b00);
		repeat (40) @(posedge pclk);
		pins(2'b10);
		wr(CTRL_ADDR, 32'h0000_0000);
		pins(2'b01);
		// tick period (1+1)*16 = 32 cycles: about 10 steps in 320 cycles
		wr(PRESC_ADDR, 32'h0000_0001);
		wr(DIVSEL_ADDR, 32'h0000_0003);
		wr(CNT_BUF_ADDR[0], 32'h0000_0064);
		wr(CTRL_ADDR, 32'h0000_0002);
		wr(CTRL_ADDR, 32'h0000_0001);
		repeat (320) @(posedge pclk);
		wr(CTRL_ADDR, 32'h0000_0000);
		rd(OBS_ADDR[0]);
		check({31'h0, (rdat >= 32'd88 && rdat <= 32'd91)}, 32'h1);
		report_and_stop();
	end
endmodule // pwm_timer_test
